/* verilog/phf_pkg.sv */
// Overview of operation
// RQ1 - Internal clocking drives both line clocks; external clocking takes them from outside.
// RQ2 - Internal line rate is programmable from 2400 to 2048000 bps.
// RQ3 - External rate leaves hardware alone; zero reads 1000000, maximum 6312000 bps.
// RQ4 - Line code is NRZ or NRZI per interface, NRZ after reset.
// RQ5 - Flag idle sends back-to-back 7E octets whenever no frame is sent.
// RQ6 - Mark idle holds the line at one between frames.
// RQ7 - Zero to fifteen extra flags go between frames, zero after reset.
// RQ8 - Receive size limit is programmable 576 to 4089 bytes, 2048 after reset.
// RQ9 - Loopback check is on after reset; magic values come from the clock.
// RQ10 - Received magic equal to last sent magic forces link renegotiation.
// RQ11 - The peer escapes character N when bit N of escape_char_map is set.
// RQ12 - escape_char_map resets to 0A0000, flagging XON and XOFF.
// RQ13 - Synchronous transparency uses bit stuffing; escape_char_map has no effect.
// RQ14 - Address and control bytes FF 03 may be dropped, saving two bytes.
// RQ15 - Receiver accepts frames with or without address and control bytes.
// RQ16 - Transmitter omits address and control bytes only when the peer accepts that.
// RQ17 - Link control frames always carry address and control bytes.
// RQ18 - Zero inserted after five ones inside frames, removed on receive.
package phf_pkg;
	// Register offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SPEED = 8'h04;
	localparam logic [7:0] OFF_MRU = 8'h08;
	localparam logic [7:0] OFF_ESC_MAP = 8'h0C;
	localparam logic [7:0] OFF_CMD = 8'h10;
	localparam logic [7:0] OFF_MAGIC_TX = 8'h14;
	localparam logic [7:0] OFF_MAGIC_RX = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	// Control fields
	localparam int CTL_INTCLK = 0;
	localparam int CTL_NRZI = 1;
	localparam int CTL_MARK = 2;
	localparam int CTL_MAGIC = 3;
	localparam int CTL_ADCOMP_LOC = 4;
	localparam int CTL_ADCOMP_PEER = 5;
	localparam int CTL_GAP_LSB = 8;
	// Status fields
	localparam int ST_LOOP = 0;
	localparam int ST_OVER = 1;
	localparam int ST_ABORT = 2;
	localparam int ST_BUSY = 3;
	// Values after reset and limits
	localparam logic [31:0] ESC_MAP_RST = 32'h000A0000;
	localparam logic [11:0] MRU_RST = 12'h800;
	localparam logic [11:0] MRU_MIN = 12'h240;
	localparam logic [11:0] MRU_MAX = 12'hFF9;
	localparam logic [22:0] RATE_INT_MIN = 23'h000960;
	localparam logic [22:0] RATE_INT_MAX = 23'h1F4000;
	localparam logic [22:0] RATE_EXT_DEF = 23'h0F4240;
	localparam logic [22:0] RATE_EXT_MAX = 23'h605040;
	// Clock rate and rate generator half period
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam logic [23:0] NCO_HALF = 24'(CLK_HZ / 2);
	// Line octets and run lengths
	localparam logic [7:0] FLAG_OCTET = 8'h7E;
	localparam logic [7:0] ADDR_OCTET = 8'hFF;
	localparam logic [7:0] CTRL_OCTET = 8'h03;
	localparam logic [3:0] OCTET_BITS = 4'h8;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [2:0] ABORT_RUN = 3'h6;
	// Transmit sequencer phases
	typedef enum logic [1:0] {TP_IDLE, TP_CTRL, TP_DATA} phf_txph_t;
endpackage: phf_pkg

/* verilog/phf_tx_bits.sv */
`timescale 1ns/1ns
`default_nettype none
module phf_tx_bits (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Line timing and mode
	input wire logic bit_tick,
	input wire logic nrzi,
	input wire logic mark_idle,
	input wire logic [3:0] gap,
	// Octet handoff
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic in_ready,
	output logic busy,
	// Line
	output logic line_out
);
	import phf_pkg::*;

	typedef struct packed {
		logic [7:0] sh;
		logic [3:0] cnt;
		logic [2:0] ones;
		logic fl, mk, infr, lastb;
		logic [3:0] gapn;
		logic lvl, line;
	} phf_txb_t;

	phf_txb_t s, n;
	logic b;

	// One line bit per tick
	always_comb begin
		n = s;
		in_ready = 1'b0;
		b = 1'b1;
		if (bit_tick) begin
			// RQ18 zero after five ones
			if (!s.fl && s.ones == STUFF_RUN) begin
				b = 1'b0;
				n.ones = '0;
			end else begin
				if (s.cnt == 4'h0) begin
					n.cnt = OCTET_BITS;
					n.fl = 1'b1;
					n.mk = 1'b0;
					n.sh = FLAG_OCTET;
					if (s.infr && !s.lastb && in_valid) begin
						in_ready = 1'b1;
						n.sh = in_data;
						n.fl = 1'b0;
						n.lastb = in_last;
					end else if (s.infr) begin
						n.infr = 1'b0;
						n.lastb = 1'b0;
						n.gapn = gap;
					end else if (s.gapn != 4'h0) begin
						// RQ7 extra gap flags
						n.gapn = s.gapn - 4'h1;
					end else if (in_valid) begin
						n.infr = 1'b1;
					end else begin
						// RQ6 mark or RQ5 flag idle
						n.mk = mark_idle;
					end
				end
				b = n.sh[0] | n.mk;
				n.sh = {1'b0, n.sh[7:1]};
				n.cnt = n.cnt - 4'h1;
				n.ones = (b && !n.fl) ? n.ones + 3'h1 : 3'h0;
			end
			// RQ4 line code
			if (n.mk) begin
				n.lvl = 1'b1;
				n.line = 1'b1;
			end else begin
				n.lvl = b ? s.lvl : ~s.lvl;
				n.line = nrzi ? n.lvl : b;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.lvl <= 1'b1;
			s.line <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign busy = s.infr | (s.gapn != 4'h0);
	assign line_out = s.line;
endmodule: phf_tx_bits
`default_nettype wire

/* verilog/phf_rx_bits.sv */
`timescale 1ns/1ns
`default_nettype none
module phf_rx_bits (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Line timing and mode
	input wire logic bit_tick,
	input wire logic line_in,
	input wire logic nrzi,
	// Octets out, one behind the line
	output logic out_valid,
	output logic [7:0] out_data,
	output logic [7:0] out_next,
	output logic out_last,
	output logic out_abort
);
	import phf_pkg::*;

	typedef struct packed {
		logic prev;
		logic [7:0] hist, acc, pend;
		logic [2:0] ones;
		logic [3:0] cnt;
		logic infr, pv;
		logic ov, ol, ab;
		logic [7:0] od, on;
	} phf_rxb_t;

	phf_rxb_t s, n;
	logic b;

	// Flag hunt, destuffing and octet assembly
	always_comb begin
		n = s;
		n.ov = 1'b0;
		n.ab = 1'b0;
		b = 1'b0;
		if (bit_tick) begin
			// RQ4 line decode
			b = nrzi ? (line_in == s.prev) : line_in;
			n.prev = line_in;
			n.hist = {b, s.hist[7:1]};
			if (n.hist == FLAG_OCTET) begin
				if (s.infr && s.pv) begin
					n.ov = 1'b1;
					n.od = s.pend;
					n.ol = 1'b1;
				end
				n.infr = 1'b1;
				n.cnt = '0;
				n.pv = 1'b0;
				n.ones = '0;
			end else if (b && s.ones == ABORT_RUN) begin
				n.ab = s.infr;
				n.infr = 1'b0;
				n.pv = 1'b0;
			end else if (!b && s.ones == STUFF_RUN) begin
				// RQ18 drop stuffed zero
				n.ones = '0;
			end else begin
				n.ones = b ? ((s.ones == 3'h7) ? s.ones : s.ones + 3'h1) : 3'h0;
				if (s.infr) begin
					n.acc = {b, s.acc[7:1]};
					n.cnt = s.cnt + 4'h1;
					if (n.cnt == OCTET_BITS) begin
						n.cnt = '0;
						n.ov = s.pv;
						n.od = s.pend;
						n.on = n.acc;
						n.ol = 1'b0;
						n.pend = n.acc;
						n.pv = 1'b1;
					end
				end
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign out_valid = s.ov;
	assign out_data = s.od;
	assign out_next = s.on;
	assign out_last = s.ol;
	assign out_abort = s.ab;
endmodule: phf_rx_bits
`default_nettype wire

/* verilog/phf_framer.sv */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module phf_framer (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [phf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Transmit byte stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_lcp,
	output logic tx_ready,
	// Receive byte stream
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	output logic rx_err,
	// Serial line
	input wire logic line_clk_in,
	input wire logic rx_line_in,
	output logic tx_line_out,
	output logic tx_clk_out,
	output logic rx_clk_out,
	output logic clk_out_en,
	// Link events
	output logic link_renegotiate
);
	import phf_pkg::*;

	typedef struct packed {
		logic int_clk, nrzi, mark, magic_en, adcomp_loc, adcomp_peer;
		logic [3:0] gap;
		logic [22:0] speed;
		logic [11:0] mru;
		logic [31:0] esc_map, rnd, magic_tx, rdata;
		logic st_loop, st_over, st_abort;
		logic err, reneg;
		logic [23:0] nco;
		logic gclk, lc1, lc2, cprev, rd1, rd2;
		phf_txph_t txph;
		logic rfirst, rskip, rover;
		logic [12:0] rcnt;
		logic rv, rl, re;
		logic [7:0] rd;
	} phf_main_t;

	phf_main_t s, n;

	logic clk_now, rise, fall;
	logic setup, access, wr, mapped;
	logic need_hdr;
	logic bv, bl, b_ready, tx_busy;
	logic [7:0] bd;
	logic rb_valid, rb_last, rb_abort;
	logic [7:0] rb_data, rb_next;
	logic [22:0] rate_int, rate_rd;
	logic [31:0] rmux, ctrl_w, stat_w;
	logic [12:0] mru_w;

	// Internal rate clamp, then the rate software reads back
	always_comb begin
		// RQ2 internal rate range
		if (s.speed < RATE_INT_MIN) begin
			rate_int = RATE_INT_MIN;
		end else if (s.speed > RATE_INT_MAX) begin
			rate_int = RATE_INT_MAX;
		end else begin
			rate_int = s.speed;
		end
		// RQ3 external rate only reported
		if (s.int_clk) begin
			rate_rd = rate_int;
		end else if (s.speed == 23'h0) begin
			rate_rd = RATE_EXT_DEF;
		end else if (s.speed > RATE_EXT_MAX) begin
			rate_rd = RATE_EXT_MAX;
		end else begin
			rate_rd = s.speed;
		end
	end

	// Line clock choice and edges
	always_comb begin
		// RQ1 clock source
		clk_now = s.int_clk ? s.gclk : s.lc2;
		rise = clk_now & ~s.cprev;
		fall = ~clk_now & s.cprev;
	end

	// Register words and read mux
	always_comb begin
		ctrl_w = '0;
		ctrl_w[CTL_INTCLK] = s.int_clk;
		ctrl_w[CTL_NRZI] = s.nrzi;
		ctrl_w[CTL_MARK] = s.mark;
		ctrl_w[CTL_MAGIC] = s.magic_en;
		ctrl_w[CTL_ADCOMP_LOC] = s.adcomp_loc;
		ctrl_w[CTL_ADCOMP_PEER] = s.adcomp_peer;
		ctrl_w[CTL_GAP_LSB +: 4] = s.gap;
		stat_w = '0;
		stat_w[ST_LOOP] = s.st_loop;
		stat_w[ST_OVER] = s.st_over;
		stat_w[ST_ABORT] = s.st_abort;
		stat_w[ST_BUSY] = tx_busy;
		mapped = 1'b1;
		rmux = '0;
		case (paddr)
			OFF_CTRL: rmux = ctrl_w;
			OFF_SPEED: rmux = {9'h000, rate_rd};
			OFF_MRU: rmux = {20'h00000, s.mru};
			OFF_ESC_MAP: rmux = s.esc_map;
			OFF_CMD: rmux = '0;
			OFF_MAGIC_TX: rmux = s.magic_tx;
			OFF_MAGIC_RX: rmux = '0;
			OFF_STATUS: rmux = stat_w;
			default: mapped = 1'b0;
		endcase
	end

	// Transmit header insertion and byte handoff
	always_comb begin
		// RQ14 RQ16 RQ17 header FF 03 choice
		need_hdr = !(s.adcomp_peer && !tx_lcp);
		bv = 1'b0;
		bd = tx_data;
		bl = 1'b0;
		tx_ready = 1'b0;
		case (s.txph)
			TP_IDLE: begin
				bv = tx_valid;
				bd = need_hdr ? ADDR_OCTET : tx_data;
				bl = !need_hdr && tx_last;
				tx_ready = !need_hdr && b_ready;
			end
			TP_CTRL: begin
				bv = 1'b1;
				bd = CTRL_OCTET;
			end
			TP_DATA: begin
				bv = tx_valid;
				bl = tx_last;
				tx_ready = b_ready;
			end
			default: begin
				bv = 1'b0;
			end
		endcase
	end

	// Next state of the whole block
	always_comb begin
		n = s;
		n.reneg = 1'b0;
		n.rv = 1'b0;
		// RQ9 free counter as random source
		n.rnd = s.rnd + 32'h1;
		setup = psel && !penable;
		access = psel && penable;
		wr = access && pwrite && !s.err;
		mru_w = '0;

		// Synchronisers for line clock and receive data
		n.lc1 = line_clk_in;
		n.lc2 = s.lc1;
		n.rd1 = rx_line_in;
		n.rd2 = s.rd1;
		n.cprev = clk_now;

		// APB setup phase captures read data and decode
		if (setup) begin
			n.rdata = (pwrite || !mapped) ? 32'h0 : rmux;
			n.err = !mapped;
		end

		// APB write at the access edge
		if (wr) begin
			case (paddr)
				OFF_CTRL: begin
					n.int_clk = pwdata[CTL_INTCLK];
					// RQ4 line code select
					n.nrzi = pwdata[CTL_NRZI];
					n.mark = pwdata[CTL_MARK];
					n.magic_en = pwdata[CTL_MAGIC];
					// RQ15 local setting is stored only; receive strips FF 03 either way
					n.adcomp_loc = pwdata[CTL_ADCOMP_LOC];
					n.adcomp_peer = pwdata[CTL_ADCOMP_PEER];
					// RQ7 gap flag count
					n.gap = pwdata[CTL_GAP_LSB +: 4];
				end
				OFF_SPEED: begin
					n.speed = (pwdata[31:23] != 9'h0) ? 23'h7FFFFF : pwdata[22:0];
				end
				OFF_MRU: begin
					// RQ8 size limit clamp
					mru_w = pwdata[12:0];
					if (pwdata[31:13] != 19'h0 || mru_w > {1'b0, MRU_MAX}) begin
						n.mru = MRU_MAX;
					end else if (mru_w < {1'b0, MRU_MIN}) begin
						n.mru = MRU_MIN;
					end else begin
						n.mru = mru_w[11:0];
					end
				end
				// RQ13 stored for software only
				OFF_ESC_MAP: n.esc_map = pwdata;
				OFF_CMD: begin
					if (pwdata[0]) begin
						n.magic_tx = s.magic_en ? s.rnd : 32'h0;
					end
				end
				OFF_MAGIC_RX: begin
					// RQ10 looped link detection
					if (s.magic_en && pwdata == s.magic_tx) begin
						n.reneg = 1'b1;
						n.st_loop = 1'b1;
					end
				end
				OFF_STATUS: begin
					n.st_loop = s.st_loop & ~pwdata[ST_LOOP];
					n.st_over = s.st_over & ~pwdata[ST_OVER];
					n.st_abort = s.st_abort & ~pwdata[ST_ABORT];
				end
				default: begin
					n.err = s.err;
				end
			endcase
		end

		// RQ2 rate generator, stops with the external select write
		if (n.int_clk) begin
			n.nco = s.nco + {1'b0, rate_int};
			if (n.nco >= NCO_HALF) begin
				n.nco = n.nco - NCO_HALF;
				n.gclk = ~s.gclk;
			end
		end else begin
			n.nco = '0;
			n.gclk = 1'b0;
		end

		// Transmit sequencer phase
		case (s.txph)
			TP_IDLE: begin
				if (tx_valid && b_ready) begin
					if (need_hdr) begin
						n.txph = TP_CTRL;
					end else if (!tx_last) begin
						n.txph = TP_DATA;
					end
				end
			end
			TP_CTRL: begin
				if (b_ready) begin
					n.txph = TP_DATA;
				end
			end
			TP_DATA: begin
				if (tx_valid && b_ready && tx_last) begin
					n.txph = TP_IDLE;
				end
			end
			default: n.txph = TP_IDLE;
		endcase

		// Receive header strip and size limit; sets follow clears
		if (rb_abort) begin
			n.st_abort = 1'b1;
			n.rfirst = 1'b1;
			n.rskip = 1'b0;
			n.rover = 1'b0;
			n.rcnt = '0;
		end
		if (rb_valid) begin
			// RQ15 strip FF 03 when present
			if (s.rfirst && rb_data == ADDR_OCTET && !rb_last && rb_next == CTRL_OCTET) begin
				n.rskip = 1'b1;
				n.rfirst = 1'b0;
			end else if (s.rskip) begin
				n.rskip = 1'b0;
			end else begin
				n.rfirst = 1'b0;
				// RQ8 oversize frames flagged
				if (s.rcnt >= {1'b0, s.mru}) begin
					n.rover = 1'b1;
				end else begin
					n.rcnt = s.rcnt + 13'h1;
				end
				if (rb_last || !n.rover) begin
					n.rv = 1'b1;
					n.rd = rb_data;
					n.rl = rb_last;
					n.re = rb_last && n.rover;
				end
			end
			if (rb_last) begin
				if (n.rover) begin
					n.st_over = 1'b1;
				end
				n.rfirst = 1'b1;
				n.rskip = 1'b0;
				n.rover = 1'b0;
				n.rcnt = '0;
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			// RQ9 loopback check on
			s.magic_en <= 1'b1;
			// RQ12 escape map after reset
			s.esc_map <= ESC_MAP_RST;
			s.mru <= MRU_RST;
			s.rfirst <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// Bit engine, octets shift out on falling line clock
	phf_tx_bits u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.bit_tick(fall),
		.nrzi(s.nrzi),
		.mark_idle(s.mark),
		.gap(s.gap),
		.in_valid(bv),
		.in_data(bd),
		.in_last(bl),
		.in_ready(b_ready),
		.busy(tx_busy),
		.line_out(tx_line_out)
	);

	// Bit engine, line sampled on rising line clock
	phf_rx_bits u_rx (
		.pclk(pclk),
		.presetn(presetn),
		.bit_tick(rise),
		.line_in(s.rd2),
		.nrzi(s.nrzi),
		.out_valid(rb_valid),
		.out_data(rb_data),
		.out_next(rb_next),
		.out_last(rb_last),
		.out_abort(rb_abort)
	);

	// Outputs
	assign prdata = s.rdata;
	assign pready = 1'b1;
	assign pslverr = s.err;
	assign rx_valid = s.rv;
	assign rx_data = s.rd;
	assign rx_last = s.rl;
	assign rx_err = s.re;
	// RQ1 both clocks driven only when internal
	assign tx_clk_out = s.gclk;
	assign rx_clk_out = s.gclk;
	assign clk_out_en = s.int_clk;
	assign link_renegotiate = s.reneg;
endmodule: phf_framer
`default_nettype wire

/* verif/phf_framer_chk_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module phf_framer_chk (
	// Bus side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [phf_pkg::ADDR_W-1:0] paddr,
	input wire logic pslverr,
	// Streams and line
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic tx_clk_out,
	input wire logic rx_clk_out,
	input wire logic clk_out_en,
	input wire logic link_renegotiate
);
	import phf_pkg::*;
	logic wr_rx;
	logic wr_ctl;
	logic mapped;
	// Decoded bus accesses
	assign wr_rx = psel && penable && pwrite && (paddr == OFF_MAGIC_RX);
	assign wr_ctl = psel && penable && pwrite && (paddr == OFF_CTRL);
	assign mapped = (paddr <= OFF_STATUS) && (paddr[1:0] == 2'h0);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_CLK_QUIET: assert property (!clk_out_en |-> !tx_clk_out && !rx_clk_out)
		else $error("line clocks driven while external");
	AST_CLK_EN_CAUSE: assert property ($rose(clk_out_en) |-> $past(wr_ctl))
		else $error("clock enable rose without control write");
	AST_RENEG_CAUSE: assert property (link_renegotiate |-> $past(wr_rx))
		else $error("renegotiation without magic write");
	AST_RENEG_PULSE: assert property (link_renegotiate |=> !link_renegotiate)
		else $error("renegotiation longer than one cycle");
	AST_RX_SPACING: assert property (rx_valid |=> !rx_valid [*8])
		else $error("received octets too close");
	AST_TX_SPACING: assert property (tx_ready |=> !tx_ready [*8])
		else $error("transmit octets taken too close");
	AST_MAP_OK: assert property (psel && penable && mapped |-> !pslverr)
		else $error("error on mapped register");
	AST_MAP_BAD: assert property (psel && penable && !mapped |-> pslverr)
		else $error("no error on unmapped offset");
endmodule: phf_framer_chk
bind phf_framer phf_framer_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .tx_ready(tx_ready),
	.rx_valid(rx_valid), .tx_clk_out(tx_clk_out), .rx_clk_out(rx_clk_out),
	.clk_out_en(clk_out_en), .link_renegotiate(link_renegotiate));
`default_nettype wire

/* verif/phf_line_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module phf_line_peer (
	// Line toward the framer
	output logic line_clk,
	output logic rx_line,
	input wire logic tx_line,
	// Line code
	input wire logic nrzi
);
	import phf_pkg::*;
	logic [7:0] win = 8'h00;
	logic [7:0] cur = 8'h00;
	logic [7:0] acc[$];
	logic [7:0] seen[$];
	logic bits[$];
	logic prev = 1'h1;
	logic open = 1'h0;
	logic b;
	logic d;
	int n = 0;
	int ones = 0;
	int frames = 0;
	int flags = 0;
	// Modem clock runs free, 400 ns
	initial begin
		line_clk = 1'h0;
		rx_line = 1'h1;
	end
	always #200 line_clk = ~line_clk;
	task automatic send(input logic [7:0] q[$]);
		int k = 0;
		foreach (q[i]) for (int j = 0; j < 8; j++) begin
			bits.push_back(q[i][j]);
			k = q[i][j] ? k + 1 : 0;
			if (k == 5) begin
				bits.push_back(1'h0);
				k = 0;
			end
		end
		for (int j = 0; j < 8; j++) bits.push_back(FLAG_OCTET[j]);
	endtask: send
	// launch on falling edge, flag fill
	always @(negedge line_clk) begin
		if (bits.size() == 0) for (int j = 0; j < 8; j++) bits.push_back(FLAG_OCTET[j]);
		b = bits.pop_front();
		rx_line <= nrzi ? (b ? rx_line : ~rx_line) : b;
	end
	// sample, undo line code and stuffing
	always @(posedge line_clk) begin
		d = nrzi ? (tx_line == prev) : tx_line;
		prev = tx_line;
		win = {d, win[7:1]};
		if (ones == 5 && !d) ones = 0;
		else begin
			ones = d ? ones + 1 : 0;
			cur = {d, cur[7:1]};
			n++;
			if (n == 8) begin
				acc.push_back(cur);
				n = 0;
			end
		end
		if (ones > 6) open = 1'h0;
		if (win == FLAG_OCTET) begin
			flags++;
			if (n == 0 && acc.size() > 0) void'(acc.pop_back());
			if (open && n == 0 && acc.size() > 0) begin
				seen = acc;
				frames++;
			end
			acc.delete();
			n = 0;
			ones = 0;
			open = 1'h1;
		end
	end
endmodule: phf_line_peer
`default_nettype wire

/* verif/test_ppp_hdlc_serial_framer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_ppp_hdlc_serial_framer;
	import phf_pkg::*;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, tx_ready, rx_valid, rx_last, rx_err;
	logic tx_valid = 1'h0;
	logic tx_last = 1'h0;
	logic tx_lcp = 1'h0;
	logic line_nrzi = 1'h0;
	logic [7:0] tx_data = 8'h00;
	logic [7:0] rx_data;
	logic [7:0] rxq[$];
	logic line_clk, rx_line, tx_line_out, tx_clk_out, rx_clk_out, clk_out_en, link_renegotiate;
	int err_count = 0;
	int comparisons = 0;
	int rx_frames = 0;
	always #25 pclk = ~pclk;
	phf_framer i_phf_framer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.tx_lcp(tx_lcp), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .rx_err(rx_err), .line_clk_in(line_clk), .rx_line_in(rx_line),
		.tx_line_out(tx_line_out), .tx_clk_out(tx_clk_out), .rx_clk_out(rx_clk_out),
		.clk_out_en(clk_out_en), .link_renegotiate(link_renegotiate));
	phf_line_peer i_phf_line_peer (.line_clk(line_clk), .rx_line(rx_line),
		.tx_line(tx_line_out), .nrzi(line_nrzi));
	// Collect received octets
	always @(posedge pclk) begin
		if (rx_valid === 1'h1) rxq.push_back(rx_data);
		if (rx_valid === 1'h1 && rx_last === 1'h1) rx_frames++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask: check
	task complete_run;
		$display("Counts: %0d compares, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask: complete_run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
		int n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dv;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) begin
			n++;
			if (n > 100) begin
				err_count++;
				complete_run();
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask: apb
	task automatic wait_chg(ref int v, input int base);
		int n = 0;
		while (v == base) begin
			n++;
			if (n > 30000) begin
				err_count++;
				complete_run();
			end
			@(posedge pclk);
		end
	endtask: wait_chg
	task automatic cmp_q(input logic [7:0] got[$], input logic [7:0] exp[$]);
		check(32'(got.size()), 32'(exp.size()));
		foreach (exp[k]) if (k < got.size()) check({24'h0, got[k]}, {24'h0, exp[k]});
	endtask: cmp_q
	task automatic send_tx(input logic [7:0] q[$], input logic lcp);
		int i = 0;
		int n = 0;
		@(posedge pclk);
		tx_valid <= 1'h1;
		tx_lcp <= lcp;
		tx_data <= q[0];
		tx_last <= (q.size() == 1);
		while (i < q.size()) begin
			@(posedge pclk);
			n++;
			if (n > 5000) begin
				err_count++;
				complete_run();
			end
			if (tx_ready === 1'h1) begin
				i++;
				if (i < q.size()) tx_data <= q[i];
				if (i < q.size()) tx_last <= (i == q.size() - 1);
			end
		end
		tx_valid <= 1'h0;
		tx_last <= 1'h0;
	endtask: send_tx
	task automatic t_reset;
		logic [7:0] a[5] = '{OFF_CTRL, OFF_SPEED, OFF_MRU, OFF_ESC_MAP, OFF_STATUS};
		logic [31:0] e[5] = '{32'h8, 32'hF4240, 32'h800, ESC_MAP_RST, 32'h0};
		for (int k = 0; k < 5; k++) begin
			apb(1'h0, a[k], 32'h0);
			check(rd, e[k]);
		end
		$display("reset values done");
	endtask: t_reset
	task automatic t_regs;
		logic [7:0] a[8] = '{OFF_SPEED, OFF_SPEED, OFF_CTRL, OFF_SPEED, OFF_SPEED, OFF_MRU,
			OFF_MRU, OFF_MRU};
		logic [31:0] w[8] = '{32'h0, 32'h6ACFC0, 32'h9, 32'h64, 32'h2DC6C0, 32'h64, 32'h1388, 32'h3E8};
		logic [31:0] e[8] = '{32'hF4240, 32'h605040, 32'h9, 32'h960, 32'h1F4000, 32'h240,
			32'hFF9, 32'h3E8};
		int chg = 0;
		logic last;
		for (int k = 0; k < 8; k++) begin
			apb(1'h1, a[k], w[k]);
			apb(1'h0, a[k], 32'h0);
			check(rd, e[k]);
		end
		check(32'(clk_out_en), 32'h1);
		last = tx_clk_out;
		repeat (200) begin
			@(posedge pclk);
			if (tx_clk_out !== last) chg++;
			last = tx_clk_out;
		end
		check(32'(chg >= 38 && chg <= 44), 32'h1);
		check(32'(rx_clk_out), 32'(tx_clk_out));
		apb(1'h1, OFF_CTRL, 32'h8);
		apb(1'h0, 8'h20, 32'h0);
		check(32'(err), 32'h1);
		check(32'(clk_out_en), 32'h0);
		$display("register access done");
	endtask: t_regs
	task automatic t_magic;
		logic [31:0] m;
		apb(1'h1, OFF_CMD, 32'h1);
		apb(1'h0, OFF_MAGIC_TX, 32'h0);
		m = rd;
		for (int k = 0; k < 3; k++) begin
			if (k == 2) apb(1'h1, OFF_CTRL, 32'h0);
			apb(1'h1, OFF_MAGIC_RX, (k == 1) ? m + 32'h1 : m);
			@(negedge pclk);
			check(32'(link_renegotiate), 32'(k == 0));
			apb(1'h0, OFF_STATUS, 32'h0);
			check(32'(rd[0]), 32'(k == 0));
			apb(1'h1, OFF_STATUS, 32'h1);
		end
		apb(1'h1, OFF_CTRL, 32'h8);
		$display("loop check done");
	endtask: t_magic
	task automatic t_tx;
		logic [7:0] dq[$] = '{8'hFF, 8'h3E, 8'h7E};
		logic [7:0] e[$];
		logic [3:0] ok = 4'h6;
		logic [3:0] lc = 4'h4;
		logic [3:0] nz = 4'h8;
		logic [3:0] hd = 4'hD;
		int base;
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, OFF_CTRL, {26'h0, ok[k], 3'h2, nz[k], 1'h0});
			line_nrzi <= nz[k];
			repeat (200) @(posedge pclk);
			base = i_phf_line_peer.frames;
			send_tx(dq, lc[k]);
			wait_chg(i_phf_line_peer.frames, base);
			e = dq;
			if (hd[k]) e = {8'hFF, 8'h03, dq};
			cmp_q(i_phf_line_peer.seen, e);
		end
		apb(1'h1, OFF_CTRL, 32'h8);
		line_nrzi <= 1'h0;
		$display("transmit framing done");
	endtask: t_tx
	task automatic t_rx;
		int base;
		apb(1'h1, OFF_CTRL, 32'h18);
		repeat (200) @(posedge pclk);
		rxq.delete();
		base = rx_frames;
		i_phf_line_peer.send('{8'hFF, 8'h03, 8'h11, 8'h7E, 8'hFF});
		wait_chg(rx_frames, base);
		cmp_q(rxq, '{8'h11, 8'h7E, 8'hFF});
		rxq.delete();
		base = rx_frames;
		i_phf_line_peer.send('{8'h22, 8'hF8});
		wait_chg(rx_frames, base);
		cmp_q(rxq, '{8'h22, 8'hF8});
		check(32'(rx_err), 32'h0);
		apb(1'h1, OFF_CTRL, 32'h8);
		$display("receive framing done");
	endtask: t_rx
	task automatic t_idle;
		int f0;
		int base;
		f0 = i_phf_line_peer.flags;
		repeat (640) @(posedge pclk);
		f0 = i_phf_line_peer.flags - f0;
		check(32'(f0 >= 9 && f0 <= 11), 32'h1);
		apb(1'h1, OFF_CTRL, 32'h30C);
		repeat (1280) @(posedge pclk);
		f0 = i_phf_line_peer.flags;
		base = i_phf_line_peer.frames;
		send_tx('{8'h5A}, 1'h0);
		wait_chg(i_phf_line_peer.frames, base);
		repeat (1280) @(posedge pclk);
		check(32'(i_phf_line_peer.flags - f0), 32'h5);
		check(32'(tx_line_out), 32'h1);
		apb(1'h1, OFF_CTRL, 32'h8);
		$display("idle fill done");
	endtask: t_idle
	// Main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_regs();
		t_magic();
		t_tx();
		t_rx();
		t_idle();
		complete_run();
	end
endmodule: test_ppp_hdlc_serial_framer
`default_nettype wire
